// ===== src/sdic_link_shift.sv
// Purpose: Link-side 24-bit shift register clocked by the host shift clock
// Assumes: Host drives data valid around each falling shift clock edge
// Notes:   Frame select high clears the frame; the shift clock may stop
`timescale 1ns/1ps
module sdic_link_shift
    import sdic_pkg::*;
(
    input wire logic shift_clk,
    input wire logic frame_sel_n,
    input wire logic serial_din,
    input wire logic reset_n,
    output sdic_frame_t word_q,
    output logic done_tgl_q
);

    logic [23:0] shift_q;
    logic [4:0] cnt_q;
    logic [23:0] shift_d;
    logic last_edge;

    assign shift_d = {shift_q[22:0], serial_din};
    assign last_edge = !frame_sel_n && (cnt_q == SDIC_LAST_EDGE);

    // Select high acts at once, so an early release needs no shift clock edge
    always_ff @(negedge shift_clk or posedge frame_sel_n) begin
        if (frame_sel_n) begin
            shift_q <= SDIC_WORD_RST;
            cnt_q <= SDIC_CNT_RST;
        end else if (cnt_q != SDIC_FULL_CNT) begin
            shift_q <= shift_d;
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // Word and toggle survive the frame end, cleared only by device reset
    always_ff @(negedge shift_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_q <= SDIC_WORD_RST;
            done_tgl_q <= 1'b0;
        end else if (last_edge) begin
            word_q <= shift_d;
            done_tgl_q <= ~done_tgl_q;
        end
    end

endmodule : sdic_link_shift

// ===== src/sdic_pkg.sv
// Purpose: Shared constants, types and helpers for the serial converter front end
// Assumes: System clock of 250 MHz, host-driven shift clock on the link
// Notes:   Frame layout is fixed at 24 bits, most significant bit first
package sdic_pkg;

    // ----------------------------------------
    // Frame layout
    // ----------------------------------------
    localparam int unsigned SDIC_FRAME_BITS = 24;
    localparam int unsigned SDIC_IGNORED_BITS = 6;
    localparam int unsigned SDIC_CODE_BITS = 16;
    localparam int unsigned SDIC_NARROW_BITS = 12;
    localparam int unsigned SDIC_CNT_W = 5;
    localparam logic [4:0] SDIC_CNT_RST = 5'h00;
    localparam logic [4:0] SDIC_LAST_EDGE = 5'h17;
    localparam logic [4:0] SDIC_FULL_CNT = 5'h18;
    localparam logic [3:0] SDIC_NARROW_MASK_LOW = 4'h0;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [15:0] SDIC_CODE_RST = 16'h0000;
    localparam logic [23:0] SDIC_WORD_RST = 24'h00_0000;
    localparam logic [7:0] SDIC_COUNT_RST = 8'h00;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam real SDIC_CLK_MHZ = 250.0;
    localparam real SDIC_WAKE_FAST_US = 2.5;
    localparam real SDIC_WAKE_SLOW_US = 5.0;
    localparam int unsigned SDIC_TMR_W = 11;
    localparam int unsigned SDIC_WAKE_FAST_CYC_I = int'($ceil(SDIC_WAKE_FAST_US * SDIC_CLK_MHZ));
    localparam int unsigned SDIC_WAKE_SLOW_CYC_I = int'($ceil(SDIC_WAKE_SLOW_US * SDIC_CLK_MHZ));
    localparam logic [10:0] SDIC_WAKE_FAST_CYC = SDIC_WAKE_FAST_CYC_I[10:0];
    localparam logic [10:0] SDIC_WAKE_SLOW_CYC = SDIC_WAKE_SLOW_CYC_I[10:0];
    localparam logic [10:0] SDIC_TMR_RST = 11'h000;
    localparam logic [10:0] SDIC_TMR_ONE = 11'h001;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        SDIC_PM_NORMAL = 2'h0,
        SDIC_PM_PD_1K = 2'h1,
        SDIC_PM_PD_100K = 2'h2,
        SDIC_PM_PD_HIZ = 2'h3
    } sdic_power_mode_t;

    typedef enum logic [1:0] {
        SDIC_ST_RUN,
        SDIC_ST_DOWN,
        SDIC_ST_WAKE
    } sdic_state_t;

    typedef struct packed {
        logic [5:0] ignored;
        logic power_mode_hi;
        logic power_mode_lo;
        logic [15:0] code;
    } sdic_frame_t;

    typedef struct packed {
        logic analog_on;
        logic amp_drive;
        logic term_1k;
        logic term_100k;
    } sdic_out_stage_t;

    // Output stage steering for a power mode
    function automatic sdic_out_stage_t sdic_stage_f(input sdic_power_mode_t mode);
        sdic_out_stage_t s;
        s.analog_on = (mode == SDIC_PM_NORMAL);
        s.amp_drive = (mode == SDIC_PM_NORMAL);
        s.term_1k = (mode == SDIC_PM_PD_1K);
        s.term_100k = (mode == SDIC_PM_PD_100K);
        return s;
    endfunction : sdic_stage_f

endpackage : sdic_pkg

// ===== src/sdic_serial_dac_ctrl.sv
// Purpose: Digital front end of a single-channel voltage-output converter
// Assumes: Host drives frame select, shift clock and data; system clock at 250 MHz
// Notes:   Link logic runs on the shift clock; results cross by toggle handshake
//
// Operation
// - Collect each frame in 24-bit shift register
// - First six frame bits are ignored
// - Bits seventeen and sixteen select power mode
// - Mode zero runs normally, amplifier drives output
// - Modes one-three: 1k, 100k, or high-impedance
// - Last sixteen bits are left-aligned code, MSB-first
// - Code loads holding register on 24th edge
// - Sample data each falling shift edge while selected
// - Execute frame at the 24th falling edge
// - Early select release clears frame, changes nothing
// - Power-up clears holding register until valid frame
// - Power-down leaves holding register untouched
// - Power-down stops analog, switches output termination
// - Output valid after wake-up delay from power-down
// - Straight binary code, twelve or sixteen bits
`timescale 1ns/1ps
module sdic_serial_dac_ctrl
    import sdic_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic shift_clk,
    input wire logic frame_sel_n,
    input wire logic serial_din,
    input wire logic narrow_variant,
    input wire logic low_supply,
    output logic [15:0] dac_code_q,
    output sdic_power_mode_t power_mode_q,
    output sdic_out_stage_t out_stage_q,
    output logic output_valid_q,
    output logic frame_busy_q,
    output logic frame_done_q,
    output logic [7:0] frame_count_q
);

    // ----------------------------------------
    // Link domain
    // ----------------------------------------
    sdic_frame_t link_word;
    logic link_tgl;

    // Frame start and per-edge sampling rely on the host framing correctly
    sdic_link_shift u_link (
        .shift_clk(shift_clk),
        .frame_sel_n(frame_sel_n),
        .serial_din(serial_din),
        .reset_n(reset_n),
        .word_q(link_word),
        .done_tgl_q(link_tgl)
    );

    // ----------------------------------------
    // Crossing into the system domain
    // ----------------------------------------
    // Toggle, frame select and the two straps all pass two flops
    logic [3:0] sync_in;
    logic [3:0] sync_rst;
    logic [3:0] sync_out;
    logic tgl_sync;
    logic sel_n_sync;
    logic narrow_sync;
    logic low_supply_sync;

    assign sync_in = {link_tgl, frame_sel_n, narrow_variant, low_supply};
    assign sync_rst = 4'h4;
    assign tgl_sync = sync_out[3];
    assign sel_n_sync = sync_out[2];
    assign narrow_sync = sync_out[1];
    assign low_supply_sync = sync_out[0];

    sdic_sync2 #(
        .W(4)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in(sync_in),
        .rst_val(sync_rst),
        .sync_q(sync_out)
    );

    // ----------------------------------------
    // Frame arrival detection
    // ----------------------------------------
    // The word is held stable on the link side for a whole frame after the
    // toggle flips, far longer than the crossing latency, so it is sampled
    // directly once the toggle has been seen here.
    logic tgl_seen_q;
    logic tgl_seen_d;
    logic frame_new;

    assign frame_new = (tgl_sync != tgl_seen_q);
    assign tgl_seen_d = tgl_sync;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tgl_seen_q <= 1'b0;
        end else if (clk_en) begin
            tgl_seen_q <= tgl_seen_d;
        end
    end

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    logic [5:0] unused_bits;
    sdic_power_mode_t new_mode;
    logic [15:0] new_code_raw;
    logic [15:0] new_code;
    logic new_is_normal;

    assign unused_bits = link_word.ignored;
    assign new_mode = sdic_power_mode_t'({link_word.power_mode_hi, link_word.power_mode_lo});
    assign new_code_raw = link_word.code;
    // Straight binary; the narrow variant drops the four low code positions
    assign new_code = narrow_sync ? {new_code_raw[15:4], SDIC_NARROW_MASK_LOW} : new_code_raw;
    assign new_is_normal = (new_mode == SDIC_PM_NORMAL);

    // ----------------------------------------
    // Holding register
    // ----------------------------------------
    logic [15:0] code_d;
    logic load_code;

    // A power-down frame keeps the old code; the normal frame that ends power-down loads its own code
    assign load_code = frame_new && new_is_normal;
    assign code_d = load_code ? new_code : dac_code_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dac_code_q <= SDIC_CODE_RST;
        end else if (clk_en) begin
            dac_code_q <= code_d;
        end
    end

    // ----------------------------------------
    // Power mode and wake-up sequencing
    // ----------------------------------------
    sdic_state_t state_q;
    sdic_state_t state_d;
    logic [10:0] tmr_q;
    logic [10:0] tmr_d;
    logic [10:0] wake_len;
    sdic_power_mode_t mode_d;
    logic tmr_done;

    assign wake_len = low_supply_sync ? SDIC_WAKE_SLOW_CYC : SDIC_WAKE_FAST_CYC;
    assign tmr_done = (tmr_q == SDIC_TMR_ONE);
    assign mode_d = frame_new ? new_mode : power_mode_q;

    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q;
        case (state_q)
            SDIC_ST_RUN: begin
                if (frame_new && !new_is_normal) begin
                    state_d = SDIC_ST_DOWN;
                end
            end
            SDIC_ST_DOWN: begin
                if (frame_new && new_is_normal) begin
                    state_d = SDIC_ST_WAKE;
                    tmr_d = wake_len;
                end
            end
            SDIC_ST_WAKE: begin
                if (frame_new && !new_is_normal) begin
                    state_d = SDIC_ST_DOWN;
                    tmr_d = SDIC_TMR_RST;
                end else if (tmr_done) begin
                    state_d = SDIC_ST_RUN;
                    tmr_d = SDIC_TMR_RST;
                end else begin
                    tmr_d = tmr_q - SDIC_TMR_ONE;
                end
            end
            default: begin
                state_d = SDIC_ST_RUN;
                tmr_d = SDIC_TMR_RST;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= SDIC_ST_RUN;
            tmr_q <= SDIC_TMR_RST;
            power_mode_q <= SDIC_PM_NORMAL;
        end else if (clk_en) begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            power_mode_q <= mode_d;
        end
    end

    // ----------------------------------------
    // Output stage steering
    // ----------------------------------------
    // Termination follows the mode at once; only the valid flag waits for
    // the amplifier to settle after power-down.
    sdic_out_stage_t stage_d;
    logic valid_d;

    assign stage_d = sdic_stage_f(mode_d);
    assign valid_d = (state_d == SDIC_ST_RUN);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_stage_q <= sdic_stage_f(SDIC_PM_NORMAL);
            output_valid_q <= 1'b1;
        end else if (clk_en) begin
            out_stage_q <= stage_d;
            output_valid_q <= valid_d;
        end
    end

    // ----------------------------------------
    // Status
    // ----------------------------------------
    // Aborted frames never flip the toggle, so only the busy flag shows them; count and done pulse do not
    logic [7:0] count_d;

    assign count_d = frame_new ? frame_count_q + 8'h01 : frame_count_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            frame_busy_q <= 1'b0;
            frame_done_q <= 1'b0;
            frame_count_q <= SDIC_COUNT_RST;
        end else if (clk_en) begin
            frame_busy_q <= ~sel_n_sync;
            frame_done_q <= frame_new;
            frame_count_q <= count_d;
        end
    end

endmodule : sdic_serial_dac_ctrl

// ===== src/sdic_sync2.sv
// Purpose: Two-flop level synchroniser into the system clock domain
// Assumes: Inputs are levels that stay put for several system clocks
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sdic_sync2 #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [W-1:0] async_in,
    input wire logic [W-1:0] rst_val,
    output logic [W-1:0] sync_q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_q <= rst_val;
            sync_q <= rst_val;
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule : sdic_sync2

// ===== testbench/sdic_host_model.sv
// Purpose: Host side of the link, sends frames bit by bit
// Assumes: Shift clock idles high and runs only inside a frame
// Notes:   Data line shows a changing value while deselected
`timescale 1ns/1ps
module sdic_host_model (
    output logic shift_clk,
    output logic frame_sel_n,
    output logic serial_din
);
    initial begin
        shift_clk = 1'b1;
        frame_sel_n = 1'b1;
        serial_din = 1'b0;
    end

    // ----------------------------------------
    // Frame transmit, nb bits taken from the top
    // ----------------------------------------
    task automatic send(input logic [23:0] w, input int nb);
        frame_sel_n = 1'b0;
        for (int i = 23; i > 23 - nb; i--) begin
            serial_din = w[i];
            #7.5 shift_clk = 1'b0;
            #7.5 shift_clk = 1'b1;
        end
        #7.5 frame_sel_n = 1'b1;
        serial_din = ~serial_din;
        // Idle gap kept above the minimum so the next select edge is seen
        #34;
    endtask : send
endmodule : sdic_host_model

// ===== testbench/sdic_serial_dac_ctrl_checker.sv
// Purpose: Port-level checks of the converter front end
// Assumes: Straps change only while no frame is in flight; clock enable stays high during a wake
// Notes:   Wake length is counted in helper logic, exact to the cycle
`timescale 1ns/1ps
module sdic_serial_dac_ctrl_checker
    import sdic_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic narrow_variant,
    input wire logic low_supply,
    input wire logic [15:0] dac_code_q,
    input wire sdic_power_mode_t power_mode_q,
    input wire sdic_out_stage_t out_stage_q,
    input wire logic output_valid_q,
    input wire logic frame_done_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // Wake steps
    // ----------------------------------------
    // Wake is far too long for a repetition or a delay range, so it is counted
    logic [10:0] low_run_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            low_run_q <= 11'h000;
        end else if (out_stage_q.amp_drive && !output_valid_q) begin
            low_run_q <= low_run_q + 11'h001;
        end else begin
            low_run_q <= 11'h000;
        end
    end

    sequence s_wake_start;
        $rose(out_stage_q.amp_drive);
    endsequence
    sequence s_wake_hold;
        !output_valid_q [*8];
    endsequence
    sequence s_wake_end;
        $rose(output_valid_q) && out_stage_q.amp_drive;
    endsequence

    property p_done_pulse;
        frame_done_q |=> !frame_done_q;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
    property p_code_cause;
        $changed(dac_code_q) |-> frame_done_q;
    endproperty
    a_code_cause: assert property (p_code_cause) else $error("code moved without frame");
    property p_mode_cause;
        $changed(power_mode_q) |-> frame_done_q;
    endproperty
    a_mode_cause: assert property (p_mode_cause) else $error("mode moved without frame");
    property p_stage;
        out_stage_q == {power_mode_q == SDIC_PM_NORMAL, power_mode_q == SDIC_PM_NORMAL,
                        power_mode_q == SDIC_PM_PD_1K, power_mode_q == SDIC_PM_PD_100K};
    endproperty
    a_stage: assert property (p_stage) else $error("output stage mismatch");
    property p_pd_keep;
        frame_done_q && power_mode_q != SDIC_PM_NORMAL |-> $stable(dac_code_q);
    endproperty
    a_pd_keep: assert property (p_pd_keep) else $error("power-down frame moved code");
    property p_narrow;
        narrow_variant && $stable(narrow_variant) && frame_done_q |-> dac_code_q[3:0] == 4'h0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow low bits set");
    property p_pd_invalid;
        power_mode_q != SDIC_PM_NORMAL |-> !output_valid_q;
    endproperty
    a_pd_invalid: assert property (p_pd_invalid) else $error("valid in power-down");
    property p_wake_hold;
        s_wake_start |-> s_wake_hold;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake ended too soon");
    property p_wake_fast;
        s_wake_end and !low_supply |-> low_run_q == SDIC_WAKE_FAST_CYC;
    endproperty
    a_wake_fast: assert property (p_wake_fast) else $error("fast wake length");
    property p_wake_slow;
        s_wake_end and low_supply |-> low_run_q == SDIC_WAKE_SLOW_CYC;
    endproperty
    a_wake_slow: assert property (p_wake_slow) else $error("slow wake length");
    property p_reset;
        disable iff (1'b0) !reset_n |=> dac_code_q == 16'h0000 && output_valid_q;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : sdic_serial_dac_ctrl_checker

bind sdic_serial_dac_ctrl sdic_serial_dac_ctrl_checker sdic_chk_i (
    .clk, .reset_n, .narrow_variant, .low_supply, .dac_code_q,
    .power_mode_q, .out_stage_q, .output_valid_q, .frame_done_q
);

// ===== testbench/sdic_serial_dac_ctrl_tb.sv
// Purpose: Self-checking bench of the converter front end
// Assumes: Host model makes the 15 ns link clock inside frames
// Notes:   Wake length checked within the crossing slack
`timescale 1ns/1ps
module sdic_serial_dac_ctrl_tb
    import sdic_pkg::*;
();
    `define CHK(nm, ex, ac) begin num_checks++; if ((ex) !== (ac)) begin err_total++; \
        $display("wrong value %s expected %h seen %h", nm, ex, ac); end end
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic narrow = 1'b0;
    logic low_sup = 1'b0;
    logic clk_en = 1'b1;
    logic busy;
    wire shift_clk, frame_sel_n, serial_din;
    logic [15:0] code;
    sdic_power_mode_t mode;
    sdic_out_stage_t stage;
    logic valid;
    logic [7:0] cnt;
    int err_total = 0;
    int num_checks = 0;
    int exp_code = 0;
    int exp_mode = 0;
    int exp_cnt = 0;
    logic [23:0] sent_q[$];

    always #2 clk = ~clk;

    sdic_host_model sdic_host_model_i (.shift_clk(shift_clk), .frame_sel_n(frame_sel_n),
        .serial_din(serial_din));
    sdic_serial_dac_ctrl sdic_serial_dac_ctrl_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .shift_clk(shift_clk), .frame_sel_n(frame_sel_n), .serial_din(serial_din),
        .narrow_variant(narrow), .low_supply(low_sup), .dac_code_q(code), .power_mode_q(mode),
        .out_stage_q(stage), .output_valid_q(valid), .frame_busy_q(busy), .frame_done_q(),
        .frame_count_q(cnt));

    // ----------------------------------------
    // Frame plus model update and compare
    // ----------------------------------------
    task automatic run(input logic [23:0] w, input int nb);
        logic [23:0] f;
        fork
            sdic_host_model_i.send(w, nb);
            begin
                repeat (4) @(posedge clk);
                #1 `CHK("busy", 1'b1, busy)
            end
        join
        @(posedge clk);
        if (nb == 24) sent_q.push_back(w);
        while (sent_q.size() > 0) begin
            f = sent_q.pop_front();
            exp_cnt++;
            exp_mode = f[17:16];
            if (exp_mode == 0) exp_code = narrow ? (f[15:0] & 16'hfff0) : f[15:0];
        end
        #1;
        `CHK("idle", 1'b0, busy)
        `CHK("count", 8'(exp_cnt), cnt)
        `CHK("code", 16'(exp_code), code)
        `CHK("mode", 2'(exp_mode), mode)
        `CHK("stage", {exp_mode == 0, exp_mode == 0, exp_mode == 1, exp_mode == 2}, stage)
    endtask : run

    task automatic wake(input int exp_cyc);
        int n;
        n = 0;
        while (valid !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK("wake", 1'b1, n > exp_cyc - 40 && n <= exp_cyc)
        if (n >= 2000) print_verdict();
    endtask : wake

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #200000 err_total++;
        print_verdict();
    end

    initial begin
        logic [23:0] w;
        void'($urandom(32'h69d5));
        repeat (10) @(posedge clk);
        #1 reset_n = 1'b1;
        `CHK("reset code", 16'h0000, code)
        `CHK("reset stage", 4'b1100, stage)
        repeat (3) @(posedge clk);
        #1;
        // Random don't-care bits must not leak into the fields
        for (int i = 0; i < 3; i++) begin
            w = 24'($urandom);
            w[17:16] = 2'b00;
            run(w, 24);
        end
        // Early release at the first, middle and last bit
        for (int n = 1; n < 24; n += 11) begin
            run(24'($urandom) | 24'h01_0000, n);
        end
        for (int m = 1; m < 4; m++) begin
            @(posedge clk);
            #1 low_sup = (m == 3);
            w = 24'($urandom);
            w[17:16] = 2'(m);
            run(w, 24);
            `CHK("pd valid", 1'b0, valid)
            w[17:16] = 2'b00;
            run(w, 24);
            wake(low_sup ? 1250 : 625);
        end
        @(posedge clk);
        #1 narrow = 1'b1;
        for (int i = 0; i < 2; i++) begin
            w = 24'($urandom);
            w[17:16] = 2'b00;
            run(w, 24);
        end
        // Frozen system side holds the result until enable returns
        @(posedge clk);
        #1 clk_en = 1'b0;
        w = 24'($urandom);
        w[17:16] = 2'b00;
        sdic_host_model_i.send(w, 24);
        `CHK("frozen code", 16'(exp_code), code)
        @(posedge clk);
        #1 clk_en = 1'b1;
        sent_q.push_back(w);
        run(w, 1);
        // Reset in mid-run from a power-down state
        w[17:16] = 2'b11;
        run(w, 24);
        @(posedge clk);
        #1 reset_n = 1'b0;
        repeat (10) @(posedge clk);
        #1 reset_n = 1'b1;
        exp_code = 0;
        exp_mode = 0;
        exp_cnt = 0;
        `CHK("rerun code", 16'h0000, code)
        `CHK("rerun mode", 2'h0, mode)
        `CHK("rerun stage", 4'b1100, stage)
        `CHK("rerun valid", 1'b1, valid)
        `CHK("rerun count", 8'h00, cnt)
        repeat (3) @(posedge clk);
        #1;
        w[17:16] = 2'b00;
        run(w, 24);
        print_verdict();
    end
endmodule : sdic_serial_dac_ctrl_tb
